// ==== cipb_map.svh ====
`ifndef CIPB_MAP_SVH
`define CIPB_MAP_SVH

// ----------------------------------------
// Register window offsets
// ----------------------------------------
`define CIPB_GRP_DATA_IN 6'h00
`define CIPB_GRP_DATA_OUT 6'h01
`define CIPB_GRP_DIR 6'h02
`define CIPB_GRP_CTRL 6'h03
`define CIPB_GRP_CELL 6'h04
`define CIPB_GRP_MCELL 6'h05
`define CIPB_GRP_MISC 6'h06
`define CIPB_OFS_MEM_MAP 8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CIPB_MEM_MAP_PERIPH_BIT 7
`define CIPB_CFG_RESET 8'h00
`define CIPB_PORT_D_MASK 8'h07
`define CIPB_JTAG_PIN_MASK 8'h63

`endif

// ==== cipb_pkg.sv ====
package cipb_pkg;
  typedef enum logic [1:0] {
    CIPB_CELL_PASS = 2'b00,
    CIPB_CELL_LATCH = 2'b01,
    CIPB_CELL_REG = 2'b10
  } cipb_cell_mode_t;
endpackage

// ==== cipb_port_block.sv ====
`include "cipb_map.svh"

module cipb_port_block #(
  parameter int PORT_W = 8,
  parameter int PORT_D_W = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register window
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Processor bus
  input wire logic addrStrobe,
  input wire logic [7:0] cpuAddr,
  input wire logic [7:0] cpuDataOut,
  input wire logic cpuWrite,
  output logic [7:0] periphRdData,
  // Programmed configuration
  input wire logic [3:0][7:0] cfgLogicOut,
  input wire logic [3:0][7:0] cfgOeDefined,
  input wire logic [2:0][1:0] cfgCellMode,
  input wire logic [2:0] cfgCellTermClk,
  // Logic array
  input wire logic [3:0][7:0] oeTerm,
  input wire logic [3:0][7:0] macroOut,
  input wire logic [2:0] externalChipSelects,
  input wire logic [2:0][1:0] cellTerm,
  input wire logic peripheralSelectA,
  input wire logic peripheralSelectB,
  output logic [2:0][7:0] cellBus,
  // JTAG pins on third port
  input wire logic [7:0] jtagPinOut,
  input wire logic [7:0] jtagPinOe,
  // Pins
  input wire logic [3:0][7:0] pinIn,
  output logic [3:0][7:0] pinOut,
  output logic [3:0][7:0] pinOe
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (PORT_W != 8 || PORT_D_W < 1 || PORT_D_W > 8) begin : gBadWidth
    $error("cipb_port_block: unsupported port widths");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0][7:0] dataOut;
  logic [3:0][7:0] dir;
  logic [1:0][7:0] ctrl;
  logic [7:0] memMap;
  logic [7:0] addrLatch;
  logic [2:0][7:0] cellQ;
  logic [2:0][1:0] cellEnPrev;
  logic [2:0][1:0] cellEn;
  localparam logic [7:0] JTAG_MASK = `CIPB_JTAG_PIN_MASK;
  logic [3:0][7:0] portMask;
  logic [5:0] grp;
  logic [1:0] port;
  logic periphMode;
  logic bufferOn;

  assign grp = regAddr[7:2];
  assign port = regAddr[1:0];
  assign periphMode = memMap[`CIPB_MEM_MAP_PERIPH_BIT];
  assign bufferOn = periphMode && peripheralSelectA && peripheralSelectB;

  always_comb begin
    portMask = '1;
    portMask[3] = 8'((1 << PORT_D_W) - 1);
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dataOut <= '0;
      dir <= '0;
    end else if (regWr && grp == `CIPB_GRP_DATA_OUT) begin
      dataOut[port] <= regWrData & portMask[port];
    end else if (regWr && grp == `CIPB_GRP_DIR) begin
      dir[port] <= regWrData & portMask[port];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= '0;
    end else if (regWr && grp == `CIPB_GRP_CTRL && !port[1]) begin
      ctrl[port[0]] <= regWrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      memMap <= `CIPB_CFG_RESET;
    end else if (regWr && regAddr == `CIPB_OFS_MEM_MAP) begin
      memMap <= regWrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addrLatch <= '0;
    end else if (addrStrobe) begin
      addrLatch <= cpuAddr;
    end
  end

  // ----------------------------------------
  // Input cells
  // ----------------------------------------
  function automatic logic cellModeIs(input logic [1:0] code, input cipb_pkg::cipb_cell_mode_t mode);
    return cipb_pkg::cipb_cell_mode_t'(code) == mode;
  endfunction

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      for (int n = 0; n < 2; n++) begin
        cellEn[p][n] = cfgCellTermClk[p] ? cellTerm[p][n] : addrStrobe;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cellQ <= '0;
      cellEnPrev <= '0;
    end else begin
      cellEnPrev <= cellEn;
      for (int p = 0; p < 3; p++) begin
        for (int n = 0; n < 2; n++) begin
          if (cellModeIs(cfgCellMode[p], cipb_pkg::CIPB_CELL_LATCH) && cellEn[p][n]) begin
            cellQ[p][n*4 +: 4] <= pinIn[p][n*4 +: 4];
          end else if (cellModeIs(cfgCellMode[p], cipb_pkg::CIPB_CELL_REG) &&
                       cellEn[p][n] && !cellEnPrev[p][n]) begin
            cellQ[p][n*4 +: 4] <= pinIn[p][n*4 +: 4];
          end
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (cellModeIs(cfgCellMode[p], cipb_pkg::CIPB_CELL_PASS)) begin
        cellBus[p] = pinIn[p];
      end else begin
        cellBus[p] = cellQ[p];
      end
    end
  end

  // ----------------------------------------
  // Pin output mux and driver enable
  // ----------------------------------------
  function automatic logic pinOeOf(input logic oeDef, input logic term, input logic logicOut,
                                   input logic dirBit);
    if (oeDef) begin
      return term | dirBit;
    end
    return logicOut | dirBit;
  endfunction

  always_comb begin
    logic isCtrl;
    logic logicSrc;
    isCtrl = 1'b0;
    logicSrc = 1'b0;
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        isCtrl = (p < 2) ? ctrl[p[0]][b] : 1'b0;
        logicSrc = (p == 3) ? ((b < 3) ? externalChipSelects[b] : 1'b0) : macroOut[p][b];
        if (isCtrl) begin
          pinOut[p][b] = addrLatch[b];
        end else if (cfgLogicOut[p][b]) begin
          pinOut[p][b] = logicSrc;
        end else begin
          pinOut[p][b] = dataOut[p][b];
        end
        pinOe[p][b] = pinOeOf(cfgOeDefined[p][b], oeTerm[p][b], cfgLogicOut[p][b], dir[p][b]) &
                      portMask[p][b];
      end
    end
    if (periphMode) begin
      pinOut[0] = cpuDataOut;
      pinOe[0] = {8{bufferOn && cpuWrite}};
    end
    for (int b = 0; b < 8; b++) begin
      if (JTAG_MASK[b]) begin
        pinOut[2][b] = jtagPinOut[b];
        pinOe[2][b] = jtagPinOe[b];
      end
    end
  end

  // ----------------------------------------
  // Peripheral read capture
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      periphRdData <= '0;
    end else if (bufferOn && !cpuWrite) begin
      periphRdData <= pinIn[0];
    end
  end

  // ----------------------------------------
  // Readback buffer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else if (!regRd) begin
      regRdData <= '0;
    end else begin
      case (grp)
        `CIPB_GRP_DATA_IN: regRdData <= pinIn[port] & portMask[port];
        `CIPB_GRP_DATA_OUT: regRdData <= dataOut[port];
        `CIPB_GRP_DIR: regRdData <= dir[port];
        `CIPB_GRP_CTRL: regRdData <= port[1] ? 8'h00 : ctrl[port[0]];
        `CIPB_GRP_CELL: regRdData <= (port == 2'd3) ? 8'h00 : cellBus[port];
        `CIPB_GRP_MCELL: regRdData <= macroOut[port] & portMask[port];
        `CIPB_GRP_MISC: regRdData <= (port == 2'd0) ? memMap : 8'h00;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_dir_readback: assert property (
    regWr && grp == `CIPB_GRP_DIR && port == 2'd1 ##1 regRd && grp == `CIPB_GRP_DIR && port == 2'd1
    |=> regRdData == $past(regWrData, 2))
    else $error("direction readback differs from write");
  chk_idle_bus_zero: assert property (
    !regRd |=> regRdData == 8'h00)
    else $error("readback bus driven without read");
  chk_dir_sole: assert property (
    !cfgOeDefined[1][2] && !cfgLogicOut[1][2] |-> pinOe[1][2] == dir[1][2])
    else $error("direction bit not sole driver enable");
  chk_oe_or_term: assert property (
    cfgOeDefined[1][4] && (oeTerm[1][4] || dir[1][4]) |-> pinOe[1][4])
    else $error("enable term or direction ignored");
  chk_addr_out: assert property (
    ctrl[0][2] && !periphMode |-> pinOut[0][2] == addrLatch[2])
    else $error("address out pin not driven from latch");
  chk_cpu_io_out: assert property (
    !ctrl[0][5] && !cfgLogicOut[0][5] && !periphMode |-> pinOut[0][5] == dataOut[0][5])
    else $error("processor output not from data-out register");
  chk_buffer_off: assert property (
    periphMode && (!peripheralSelectA || !peripheralSelectB) |-> pinOe[0] == 8'h00)
    else $error("data buffer driven with select low");
  chk_port_d_width: assert property (
    pinOe[3][7:3] == 5'h00 && dir[3][7:3] == 5'h00)
    else $error("port four drives beyond its pins");
  chk_ctrl_none_hi: assert property (
    regRd && grp == `CIPB_GRP_CTRL && port[1] |=> regRdData == 8'h00)
    else $error("control register seen on third or fourth port");
  chk_reset_input: assert property (
    $past(sys_rst) |-> dir == '0 && ctrl == '0 && memMap == 8'h00)
    else $error("configuration not cleared by reset");
  chk_jtag_override: assert property (
    pinOe[2][5] == jtagPinOe[5] && pinOut[2][1] == jtagPinOut[1])
    else $error("programming pin not taken from its own path");
  chk_chip_select: assert property (
    cfgLogicOut[3][1] |-> pinOut[3][1] == externalChipSelects[1])
    else $error("chip select not routed to fourth port");
  chk_logic_oe_on: assert property (
    cfgLogicOut[3][0] && !cfgOeDefined[3][0] |-> pinOe[3][0])
    else $error("logic output without enable term not driven");
  chk_buffer_write: assert property (
    bufferOn && cpuWrite |-> pinOe[0] == 8'hff && pinOut[0] == cpuDataOut)
    else $error("data buffer not driving processor data");
  chk_periph_read: assert property (
    bufferOn && !cpuWrite |=> periphRdData == $past(pinIn[0]))
    else $error("data buffer read not captured");
  chk_addr_latch: assert property (
    addrStrobe |=> addrLatch == $past(cpuAddr))
    else $error("address latch missed strobe");
  chk_ctrl_write: assert property (
    regWr && grp == `CIPB_GRP_CTRL && port == 2'd0 |=> ctrl[0] == $past(regWrData))
    else $error("control write not stored");
  chk_dir_write: assert property (
    regWr && grp == `CIPB_GRP_DIR && port == 2'd0 |=> dir[0] == $past(regWrData))
    else $error("direction write not stored");
  chk_memmap_write: assert property (
    regWr && regAddr == `CIPB_OFS_MEM_MAP |=> memMap == $past(regWrData))
    else $error("memory-mapping write not stored");
  chk_pass_cell: assert property (
    cfgCellMode[2] == 2'b00 |-> cellBus[2] == pinIn[2])
    else $error("pass cell not following pin");
  chk_reg_cell_hold: assert property (
    cfgCellMode[0] == 2'b10 && !(cellEn[0][0] && !cellEnPrev[0][0]) |=> cellQ[0][3:0] == $past(cellQ[0][3:0]))
    else $error("register cell changed without enable edge");
  chk_mcell_readback: assert property (
    regRd && grp == `CIPB_GRP_MCELL && port == 2'd1 |=> regRdData == $past(macroOut[1]))
    else $error("macrocell readback differs");
  chk_dout_readback: assert property (
    regRd && grp == `CIPB_GRP_DATA_OUT |=> regRdData == $past(dataOut[port]))
    else $error("data-out readback differs");
  chk_dout_port_d: assert property (
    dataOut[3][7:3] == 5'h00)
    else $error("fourth port stores bits beyond its pins");

  cov_addr_out: cover property (ctrl[0] != 8'h00 && dir[0] != 8'h00);
  cov_periph_write: cover property (bufferOn && cpuWrite);
  cov_reg_cell: cover property (cfgCellMode[0] == 2'b10 && cellQ[0] != 8'h00);
  cov_readback: cover property (regRd ##1 regRdData != 8'h00);
  cov_latch_cell: cover property (cfgCellMode[0] == 2'b01 && cellTerm[0][0]);

endmodule

// ==== cipb_pin_partner.sv ====
module cipb_pin_partner (
  // Clock
  input wire logic ref_clk,
  // Pins from the block
  input wire logic [3:0][7:0] pinOut,
  input wire logic [3:0][7:0] pinOe,
  // Bench steering
  input wire logic [31:0] extEn,
  input wire logic [31:0] extVal,
  // Pins to the block
  output logic [3:0][7:0] pinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic toggle = 1'b0;
  // ----------------------------------------
  // Released pins without extEn show a moving pattern
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    toggle <= ~toggle;
  end
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & ({32{toggle}} ^ 32'haaaaaaaa));
endmodule

// ==== test_configurable_io_port_block.sv ====
module test_configurable_io_port_block;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, sys_rst, regWr, regRd, addrStrobe, cpuWrite, peripheralSelectA, peripheralSelectB;
  logic [7:0] regAddr, regWrData, cpuAddr, cpuDataOut, jtagPinOut, jtagPinOe, regRdData, periphRdData;
  logic [3:0][7:0] cfgLogicOut, cfgOeDefined, oeTerm, macroOut, pinIn, pinOut, pinOe;
  logic [2:0][1:0] cfgCellMode, cellTerm;
  logic [2:0] cfgCellTermClk, externalChipSelects;
  logic [2:0][7:0] cellBus;
  logic [31:0] extEn, extVal;
  int mismatches = 0;
  int n_compared = 0;
  cipb_port_block u_cipb_port_block (.ref_clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .addrStrobe, .cpuAddr, .cpuDataOut, .cpuWrite, .periphRdData, .cfgLogicOut, .cfgOeDefined, .cfgCellMode,
    .cfgCellTermClk, .oeTerm, .macroOut, .externalChipSelects, .cellTerm, .peripheralSelectA,
    .peripheralSelectB, .cellBus, .jtagPinOut, .jtagPinOe, .pinIn, .pinOut, .pinOe);
  cipb_pin_partner u_cipb_pin_partner (.ref_clk, .pinOut, .pinOe, .extEn, .extVal, .pinIn);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic wrRd(input string what, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(what, {24'h0, regRdData}, {24'h0, exp});
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(what, {24'h0, regRdData}, {24'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #200us;
    mismatches++;
    summarize();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {sys_rst, regWr, regRd, addrStrobe, cpuWrite, peripheralSelectA, peripheralSelectB} = 7'h40;
    {regAddr, regWrData, cpuAddr, cpuDataOut, jtagPinOut, jtagPinOe} = '0;
    {cfgLogicOut, cfgOeDefined, oeTerm, macroOut, cfgCellMode, cellTerm} = '0;
    {cfgCellTermClk, externalChipSelects, extEn, extVal} = '0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdChk("dirA", 8'h08, 8'h00);
    rdChk("ctrlB", 8'h0d, 8'h00);
    rdChk("memMap", 8'h18, 8'h00);
    check("oeAll", pinOe, 32'h0);
    $display("test reset done");
    wr(8'h05, 8'ha5);
    wrRd("dirB", 8'h09, 8'h07, 8'h07);
    rdChk("doutB", 8'h05, 8'ha5);
    check("oeB", {24'h0, pinOe[1]}, 32'h07);
    check("outB", {29'h0, pinOut[1][2:0]}, 32'h5);
    oeTerm <= 32'h00ff1000;
    cfgOeDefined <= 32'h0000ff00;
    wr(8'h0a, 8'h04);
    tick(1);
    check("oeOr", {24'h0, pinOe[1]}, 32'h17);
    check("oeDirOnly", {24'h0, pinOe[2]}, 32'h04);
    wr(8'h0b, 8'hff);
    rdChk("dirD", 8'h0b, 8'h07);
    wr(8'h0e, 8'hff);
    rdChk("ctrlC", 8'h0e, 8'h00);
    $display("test direction done");
    // Bench drives only input pins
    extEn <= 32'h00ff0000;
    extVal <= 32'h005a0000;
    tick(3);
    rdChk("inC", 8'h02, 8'h5a);
    check("cellPass", {24'h0, cellBus[2]}, 32'h5a);
    wr(8'h0c, 8'hff);
    wr(8'h08, 8'hff);
    addrStrobe <= 1'b1;
    cpuAddr <= 8'h3c;
    @(posedge ref_clk);
    addrStrobe <= 1'b0;
    cpuAddr <= 8'hc3;
    tick(2);
    check("addrOut", {pinOe[0], pinOut[0]}, 32'hff3c);
    wr(8'h04, 8'h69);
    wr(8'h0c, 8'h00);
    tick(1);
    check("cpuIo", {24'h0, pinOut[0]}, 32'h69);
    $display("test address done");
    wr(8'h08, 8'h00);
    cfgCellMode <= 6'h02;
    extEn <= 32'h00ff00ff;
    extVal <= 32'h005a00c5;
    tick(2);
    addrStrobe <= 1'b1;
    tick(1);
    addrStrobe <= 1'b0;
    extVal <= 32'h005a003a;
    tick(2);
    check("cellReg", {24'h0, cellBus[0]}, 32'hc5);
    rdChk("cellA", 8'h10, 8'hc5);
    cfgCellMode <= 6'h01;
    cfgCellTermClk <= 3'b001;
    cellTerm <= 6'h01;
    tick(2);
    cellTerm <= 6'h00;
    extVal <= 32'h005a0000;
    tick(2);
    check("cellLatch", {24'h0, cellBus[0]}, 32'hca);
    $display("test cells done");
    wr(8'h18, 8'h80);
    // Selects qualified by fetch strobe in the array
    peripheralSelectA <= 1'b1;
    cpuWrite <= 1'b1;
    cpuDataOut <= 8'h96;
    tick(2);
    check("bufOff", {24'h0, pinOe[0]}, 32'h00);
    peripheralSelectB <= 1'b1;
    tick(1);
    check("bufWr", {pinOe[0], pinOut[0]}, 32'hff96);
    cpuWrite <= 1'b0;
    extEn <= 32'h000000ff;
    extVal <= 32'h0000003a;
    tick(3);
    check("bufRd", {24'h0, periphRdData}, 32'h3a);
    rdChk("unmapped", 8'hfc, 8'h00);
    $display("test peripheral done");
    cfgLogicOut <= 32'h03000000;
    externalChipSelects <= 3'b010;
    macroOut <= 32'h00003c00;
    jtagPinOut <= 8'h21;
    jtagPinOe <= 8'h63;
    tick(1);
    check("logicD", {pinOe[3], pinOut[3]}, 32'h0702);
    check("jtagC", {pinOe[2], pinOut[2]}, 32'h6721);
    rdChk("mcellB", 8'h15, 8'h3c);
    $display("test logic done");
    summarize();
  end
endmodule
